// ### common/ctr_defs.svh
/*
 * Constants of the conveyor status and tracking register group:
 * register offsets, status bit positions, thresholds and times.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CTR_DEFS_SVH
`define CTR_DEFS_SVH

// Register offsets on the module register port
`define CTR_OFF_STAT1    8'h58
`define CTR_OFF_STAT2    8'h59
`define CTR_OFF_US_REL   8'h69
`define CTR_OFF_US_TRK1  8'h77
`define CTR_OFF_US_TRK2  8'h78
`define CTR_OFF_REV_TRK1 8'h79
`define CTR_OFF_REV_TRK2 8'h7a
`define CTR_OFF_DS_REL   8'hb9
`define CTR_OFF_DS_TRK1  8'hc7
`define CTR_OFF_DS_TRK2  8'hc8
`define CTR_OFF_FWD_TRK1 8'hc9
`define CTR_OFF_FWD_TRK2 8'hca

// First status word bit
`define CTR_B_RESET      0
// Second status word bits
`define CTR_B_OVER_V     2
`define CTR_B_MOT_ERR    3
`define CTR_B_JAM        5
`define CTR_B_SENS_ERR   6
`define CTR_B_LOW_V      7
`define CTR_B_HOT        8
`define CTR_B_OVER_I     9
`define CTR_B_SHORT      10
`define CTR_B_NO_MOTOR   11
`define CTR_B_OVERLOAD   12
`define CTR_B_STALL      13
`define CTR_B_HALL       14
`define CTR_B_NOT_USED   15
`define CTR_B_MOT_LO     8
`define CTR_B_MOT_HI     14

// Pin vector positions into the synchroniser
`define CTR_P_JAM        0
`define CTR_P_SENS       1
`define CTR_P_SHORT      2
`define CTR_P_NOCONN     3
`define CTR_P_HALL       4
`define CTR_P_NOTUSED    5
`define CTR_PIN_W        6

// Thresholds: supply in tenths of a volt, temperature in degrees C
`define CTR_OVER_DV      10'h12c
`define CTR_LOW_DV       10'h0b4
`define CTR_HOT_C        8'h69
// Stall when speed below this percentage of selected speed
`define CTR_STALL_PCT    20'h0_000a
`define CTR_PCT_FULL     20'h0_0064

// Clock rate and overload time
`define CTR_CLK_HZ       20000000
`define CTR_OVERLOAD_S   20
`define CTR_ZERO_WORD    16'h0000

`endif

// ### common/ctr_pkg.sv
/*
 * Types shared by the conveyor status and tracking register group.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package ctr_pkg;
	typedef logic [15:0] ctr_word_t;
	typedef logic [7:0]  ctr_addr_t;
endpackage
`default_nettype wire

// ### common/ctr_sync_if.sv
/*
 * Carrier between the register group and its pin synchroniser.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface ctr_sync_if #(parameter int W = 1) ();
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport src  (output raw, input sync);
	modport sink (input raw, output sync);
endinterface
`default_nettype wire

// ### hdl/ctr_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level; bits are not coherent as a word.
 */
`default_nettype none
module ctr_sync
	import ctr_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ctr_sync_if.sink  port
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	// First stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= port.raw;
			stage2 <= stage1;
		end
	end

	assign port.sync = stage2;
endmodule // ctr_sync
`default_nettype wire

// ### hdl/ctr_regs.sv
/*
 * Read-only status and carton tracking registers of a roller zone module,
 * read by the network controller over the module register port.
 * Assumes measurements, zone states and tracking words come from logic on
 * clk_i; fault pins arrive asynchronously and are synchronised here.
 */
// Contract
// - Status word one bit 0 set by reset
// - Bit 2 while supply above 30 V
// - Bit 7 while supply below 18 V
// - Bit 3 summarises right motor faults
// - Bit 5 downstream jam, bit 6 sensor
// - Bit 8 when motor above 105 C
// - Bit 9 when current over roller limit
// - Bit 10 short, bit 11 not connected
// - Bit 12 after stall over 20 s
// - Bit 13 while slower than 10 percent
// - Bit 14 hall fault, bit 15 unused
// - Both status words are read only
// - Upstream accumulated carton tracking words shown
// - Downstream accumulated carton tracking words shown
// - Release output values mirrored for controller check
// - Forward discharged carton tracking words shown
// - Reverse discharged carton words in own registers
`default_nettype none
`include "ctr_defs.svh"
module ctr_regs
	import ctr_pkg::*;
#(
	parameter int OVERLOAD_CYC = `CTR_OVERLOAD_S * `CTR_CLK_HZ
) (
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	// Module register port
	input  wire logic      reg_rd_i,
	input  wire logic      reg_wr_i,
	input  wire ctr_addr_t reg_addr_i,
	input  wire ctr_word_t reg_wdata_i,
	output var  ctr_word_t reg_rdata_o,
	output var  logic      reg_ack_o,
	// Reset flag acknowledge from module logic
	input  wire logic      reset_flag_clr_i,
	// Supply and motor measurements
	input  wire logic [9:0]  supply_dv_i,
	input  wire logic [7:0]  motor_temp_i,
	input  wire logic [11:0] motor_cur_i,
	input  wire logic [11:0] motor_cur_lim_i,
	input  wire logic        motor_run_i,
	input  wire logic [11:0] motor_speed_i,
	input  wire logic [11:0] motor_speed_sel_i,
	// Asynchronous fault pins
	input  wire logic      jam_pin_i,
	input  wire logic      sensor_err_pin_i,
	input  wire logic      motor_short_pin_i,
	input  wire logic      motor_noconn_pin_i,
	input  wire logic      hall_err_pin_i,
	input  wire logic      motor_unused_pin_i,
	// Zone tracking and release values
	input  wire logic      us_accum_i,
	input  wire ctr_word_t us_track1_i,
	input  wire ctr_word_t us_track2_i,
	input  wire logic      ds_accum_i,
	input  wire ctr_word_t ds_track1_i,
	input  wire ctr_word_t ds_track2_i,
	input  wire ctr_word_t us_release_i,
	input  wire ctr_word_t ds_release_i,
	// Discharge to a foreign conveyor, one-cycle strobes
	input  wire logic      fwd_disch_i,
	input  wire logic      rev_disch_i,
	input  wire ctr_word_t disch_track1_i,
	input  wire ctr_word_t disch_track2_i
);
	ctr_sync_if #(.W(`CTR_PIN_W)) pins ();

	ctr_word_t   stat1;
	ctr_word_t   stat2;
	ctr_word_t   us_trk1;
	ctr_word_t   us_trk2;
	ctr_word_t   ds_trk1;
	ctr_word_t   ds_trk2;
	ctr_word_t   us_rel;
	ctr_word_t   ds_rel;
	ctr_word_t   fwd_trk1;
	ctr_word_t   fwd_trk2;
	ctr_word_t   rev_trk1;
	ctr_word_t   rev_trk2;
	ctr_word_t   next_rdata;
	logic        reset_flag;
	logic        stalled;
	logic        overload;
	logic [31:0] stall_cnt;
	logic [19:0] speed_scaled;
	logic [19:0] sel_scaled;
	logic        next_stalled;
	logic [6:0]  motor_faults;

	// Fault pins into the synchroniser
	assign pins.raw[`CTR_P_JAM]     = jam_pin_i;
	assign pins.raw[`CTR_P_SENS]    = sensor_err_pin_i;
	assign pins.raw[`CTR_P_SHORT]   = motor_short_pin_i;
	assign pins.raw[`CTR_P_NOCONN]  = motor_noconn_pin_i;
	assign pins.raw[`CTR_P_HALL]    = hall_err_pin_i;
	assign pins.raw[`CTR_P_NOTUSED] = motor_unused_pin_i;

	ctr_sync #(
		.W (`CTR_PIN_W)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.port    (pins)
	);

	// Reset flag: set while in reset, cleared by module logic
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reset_flag <= 1'b1;
		end else if (reset_flag_clr_i) begin
			reset_flag <= 1'b0;
		end
	end

	// First status word carries only the reset flag
	always_comb begin
		stat1 = `CTR_ZERO_WORD;
		stat1[`CTR_B_RESET] = reset_flag;
	end

	// Stall test: speed below a tenth of the selected speed
	assign speed_scaled = {8'h00, motor_speed_i} * `CTR_PCT_FULL;
	assign sel_scaled   = {8'h00, motor_speed_sel_i} * `CTR_STALL_PCT;
	assign next_stalled = motor_run_i && (speed_scaled < sel_scaled);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stalled <= 1'b0;
		end else begin
			stalled <= next_stalled;
		end
	end

	// Overload timer counts stalled cycles and saturates
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !stalled) begin
			stall_cnt <= 32'h0000_0000;
		end else if (stall_cnt <= 32'(OVERLOAD_CYC)) begin
			stall_cnt <= stall_cnt + 32'h0000_0001;
		end
	end

	// Overload once stalled longer than the overload time
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			overload <= 1'b0;
		end else begin
			overload <= stalled && (stall_cnt > 32'(OVERLOAD_CYC));
		end
	end

	// Second status word, rebuilt each cycle from live conditions
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stat2 <= `CTR_ZERO_WORD;
		end else begin
			stat2 <= `CTR_ZERO_WORD;
			stat2[`CTR_B_OVER_V]   <= supply_dv_i > `CTR_OVER_DV;
			stat2[`CTR_B_LOW_V]    <= supply_dv_i < `CTR_LOW_DV;
			stat2[`CTR_B_JAM]      <= pins.sync[`CTR_P_JAM];
			stat2[`CTR_B_SENS_ERR] <= pins.sync[`CTR_P_SENS];
			stat2[`CTR_B_HOT]      <= motor_temp_i > `CTR_HOT_C;
			stat2[`CTR_B_OVER_I]   <= motor_cur_i > motor_cur_lim_i;
			stat2[`CTR_B_SHORT]    <= pins.sync[`CTR_P_SHORT];
			stat2[`CTR_B_NO_MOTOR] <= pins.sync[`CTR_P_NOCONN];
			stat2[`CTR_B_OVERLOAD] <= overload;
			stat2[`CTR_B_STALL]    <= stalled;
			stat2[`CTR_B_HALL]     <= pins.sync[`CTR_P_HALL];
			stat2[`CTR_B_NOT_USED] <= pins.sync[`CTR_P_NOTUSED];
			stat2[`CTR_B_MOT_ERR]  <= |motor_faults;
		end
	end

	// Causes that feed the motor summary, same timing as their bits
	assign motor_faults = {
		pins.sync[`CTR_P_HALL],
		stalled,
		overload,
		pins.sync[`CTR_P_NOCONN],
		pins.sync[`CTR_P_SHORT],
		motor_cur_i > motor_cur_lim_i,
		motor_temp_i > `CTR_HOT_C
	};

	// Upstream tracking shown only while a carton sits accumulated
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !us_accum_i) begin
			us_trk1 <= `CTR_ZERO_WORD;
			us_trk2 <= `CTR_ZERO_WORD;
		end else begin
			us_trk1 <= us_track1_i;
			us_trk2 <= us_track2_i;
		end
	end

	// Downstream tracking shown only while a carton sits accumulated
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !ds_accum_i) begin
			ds_trk1 <= `CTR_ZERO_WORD;
			ds_trk2 <= `CTR_ZERO_WORD;
		end else begin
			ds_trk1 <= ds_track1_i;
			ds_trk2 <= ds_track2_i;
		end
	end

	// Copies of the release output registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			us_rel <= `CTR_ZERO_WORD;
			ds_rel <= `CTR_ZERO_WORD;
		end else begin
			us_rel <= us_release_i;
			ds_rel <= ds_release_i;
		end
	end

	// Forward discharge words held until the next forward discharge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fwd_trk1 <= `CTR_ZERO_WORD;
			fwd_trk2 <= `CTR_ZERO_WORD;
		end else if (fwd_disch_i) begin
			fwd_trk1 <= disch_track1_i;
			fwd_trk2 <= disch_track2_i;
		end
	end

	// Reverse discharge words kept apart from forward ones
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rev_trk1 <= `CTR_ZERO_WORD;
			rev_trk2 <= `CTR_ZERO_WORD;
		end else if (rev_disch_i) begin
			rev_trk1 <= disch_track1_i;
			rev_trk2 <= disch_track2_i;
		end
	end

	// Read decode; unmapped offsets read as zero
	always_comb begin
		case (reg_addr_i)
			`CTR_OFF_STAT1:    next_rdata = stat1;
			`CTR_OFF_STAT2:    next_rdata = stat2;
			`CTR_OFF_US_REL:   next_rdata = us_rel;
			`CTR_OFF_US_TRK1:  next_rdata = us_trk1;
			`CTR_OFF_US_TRK2:  next_rdata = us_trk2;
			`CTR_OFF_REV_TRK1: next_rdata = rev_trk1;
			`CTR_OFF_REV_TRK2: next_rdata = rev_trk2;
			`CTR_OFF_DS_REL:   next_rdata = ds_rel;
			`CTR_OFF_DS_TRK1:  next_rdata = ds_trk1;
			`CTR_OFF_DS_TRK2:  next_rdata = ds_trk2;
			`CTR_OFF_FWD_TRK1: next_rdata = fwd_trk1;
			`CTR_OFF_FWD_TRK2: next_rdata = fwd_trk2;
			default:           next_rdata = `CTR_ZERO_WORD;
		endcase
	end

	// Read data registered; holds between reads
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= `CTR_ZERO_WORD;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	// Every access is acknowledged; write data is dropped
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_ack_o <= 1'b0;
		end else begin
			reg_ack_o <= reg_rd_i || reg_wr_i;
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_read_stat1;
		reg_rd_i && (reg_addr_i == `CTR_OFF_STAT1);
	endsequence

	sequence s_read_stat2;
		reg_rd_i && (reg_addr_i == `CTR_OFF_STAT2);
	endsequence

	sequence s_write_only;
		reg_wr_i && !reg_rd_i;
	endsequence

	a_reset_flag_set: assert property (
		@(posedge clk_i) disable iff (1'b0)
		!rst_n_i ##1 (rst_n_i && !reset_flag_clr_i) ##1 s_read_stat1 ##0 rst_n_i
		|=> reg_ack_o && reg_rdata_o[`CTR_B_RESET])
		else $error("reset flag not seen after reset");

	a_over_volt: assert property (
		(supply_dv_i > `CTR_OVER_DV) |=> stat2[`CTR_B_OVER_V])
		else $error("over-voltage bit missing");

	a_low_volt: assert property (
		$rose(supply_dv_i < `CTR_LOW_DV) |=> stat2[`CTR_B_LOW_V] && !stat2[`CTR_B_OVER_V])
		else $error("low-voltage bit missing");

	a_motor_summary: assert property (
		stat2[`CTR_B_MOT_ERR] == (|stat2[`CTR_B_MOT_HI:`CTR_B_MOT_LO]))
		else $error("motor summary disagrees with causes");

	a_jam_pin: assert property (
		jam_pin_i [*4] |-> stat2[`CTR_B_JAM])
		else $error("jam bit not set after pin held");

	a_hot_motor: assert property (
		(motor_temp_i > `CTR_HOT_C) |=> stat2[`CTR_B_HOT] && stat2[`CTR_B_MOT_ERR])
		else $error("overheat bit missing");

	a_over_current: assert property (
		(motor_cur_i <= motor_cur_lim_i) |=> !stat2[`CTR_B_OVER_I])
		else $error("over-current bit without cause");

	a_stall_bit: assert property (
		next_stalled ##1 1'b1 |=> stat2[`CTR_B_STALL])
		else $error("stall bit missing");

	a_overload_wait: assert property (
		$rose(stat2[`CTR_B_OVERLOAD]) |-> $past(stall_cnt, 2) == 32'(OVERLOAD_CYC) + 32'h1)
		else $error("overload raised at wrong time");

	a_status_read: assert property (
		s_read_stat2 |=> reg_ack_o && (reg_rdata_o == $past(stat2)))
		else $error("status word read mismatch");

	a_write_ignored: assert property (
		s_write_only |=> reg_ack_o && $stable(reg_rdata_o))
		else $error("write altered read data");

	a_us_track: assert property (
		us_accum_i |=> (us_trk1 == $past(us_track1_i)) && (us_trk2 == $past(us_track2_i)))
		else $error("upstream tracking not shown");

	a_ds_track: assert property (
		!ds_accum_i |=> (ds_trk1 == `CTR_ZERO_WORD) && (ds_trk2 == `CTR_ZERO_WORD))
		else $error("downstream tracking without carton");

	a_release_copy: assert property (
		$changed(ds_release_i) |=> ds_rel == $past(ds_release_i))
		else $error("release copy stale");

	a_fwd_capture: assert property (
		fwd_disch_i ##1 !fwd_disch_i |-> fwd_trk1 == $past(disch_track1_i))
		else $error("forward tracking not captured");

	a_rev_separate: assert property (
		rev_disch_i && !fwd_disch_i |=> $stable(fwd_trk1) && rev_trk2 == $past(disch_track2_i))
		else $error("reverse capture wrong");
endmodule // ctr_regs
`default_nettype wire

// ### sim/ctr_plc_model.sv
/*
 * Controller side model: issues single reads and writes on the register port.
 * Assumes the caller enters just after a rising edge and the answer comes one edge later.
 */
`default_nettype none
module ctr_plc_model
	import ctr_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      reg_ack_i,
	input  wire ctr_word_t reg_rdata_i,
	output var  logic      reg_rd_o,
	output var  logic      reg_wr_o,
	output var  ctr_addr_t reg_addr_o,
	output var  ctr_word_t reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle port at time zero
	initial begin
		reg_rd_o = 1'h0;
		reg_wr_o = 1'h0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 16'h0000;
	end

	// One access: strobe for one edge, address held until the answer edge
	task automatic access(input logic w, input ctr_addr_t a, input ctr_word_t d,
			output ctr_word_t q, output logic ok);
		reg_rd_o = ~w;
		reg_wr_o = w;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1;
		reg_rd_o = 1'h0;
		reg_wr_o = 1'h0;
		@(posedge clk_i);
		ok = reg_ack_i;
		q = reg_rdata_i;
		#1;
		// Released lines show a changed pattern, not the old value
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
		// Let an edge pass so a following call never rewrites a line in one step
		@(posedge clk_i);
		#1;
	endtask
endmodule // ctr_plc_model
`default_nettype wire

// ### sim/tb_conveyor_status_tracking_regs.sv
/*
 * Self-checking bench of the status and tracking register group.
 * Assumes the controller model in sim/ and the shared constants header.
 */
`default_nettype none
`include "ctr_defs.svh"
module tb_conveyor_status_tracking_regs
	import ctr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		logic [9:0]  s;
		logic [7:0]  t;
		logic [11:0] c;
		logic [5:0]  p;
		logic [11:0] v;
		ctr_word_t   e;
	} ctr_row_t;

	logic        clk_i, rst_n_i, clr, run, fwd, rev, usa, dsa, rd, wr, ack;
	logic [9:0]  sup;
	logic [7:0]  temp;
	logic [11:0] cur, spd, lim, sel;
	logic [5:0]  pins;
	ctr_word_t   ut1, ut2, dt1, dt2, ur, dr, k1, k2, wdata, rdata;
	ctr_addr_t   addr;
	int          failures, compares;
	ctr_word_t   ex [12];
	ctr_addr_t   offs [12] = '{`CTR_OFF_STAT1, `CTR_OFF_STAT2, `CTR_OFF_US_REL,
		`CTR_OFF_US_TRK1, `CTR_OFF_US_TRK2, `CTR_OFF_REV_TRK1, `CTR_OFF_REV_TRK2,
		`CTR_OFF_DS_REL, `CTR_OFF_DS_TRK1, `CTR_OFF_DS_TRK2, `CTR_OFF_FWD_TRK1,
		`CTR_OFF_FWD_TRK2};
	// Supply, temperature, current, pins, speed, expected second status word
	ctr_row_t    rows [16] = '{
		'{10'h12d, 8'h19, 12'h032, 6'h00, 12'h064, 16'h0004},
		'{10'h12c, 8'h19, 12'h032, 6'h00, 12'h064, 16'h0000},
		'{10'h0b3, 8'h19, 12'h032, 6'h00, 12'h064, 16'h0080},
		'{10'h0b4, 8'h19, 12'h032, 6'h00, 12'h064, 16'h0000},
		'{10'h0f0, 8'h6a, 12'h032, 6'h00, 12'h064, 16'h0108},
		'{10'h0f0, 8'h69, 12'h032, 6'h00, 12'h064, 16'h0000},
		'{10'h0f0, 8'h19, 12'h065, 6'h00, 12'h064, 16'h0208},
		'{10'h0f0, 8'h19, 12'h064, 6'h00, 12'h064, 16'h0000},
		'{10'h0f0, 8'h19, 12'h032, 6'h01, 12'h064, 16'h0020},
		'{10'h0f0, 8'h19, 12'h032, 6'h02, 12'h064, 16'h0040},
		'{10'h0f0, 8'h19, 12'h032, 6'h04, 12'h064, 16'h0408},
		'{10'h0f0, 8'h19, 12'h032, 6'h08, 12'h064, 16'h0808},
		'{10'h0f0, 8'h19, 12'h032, 6'h10, 12'h064, 16'h4008},
		'{10'h0f0, 8'h19, 12'h032, 6'h20, 12'h064, 16'h8000},
		'{10'h0f0, 8'h19, 12'h032, 6'h00, 12'h009, 16'h2008},
		'{10'h0f0, 8'h19, 12'h032, 6'h00, 12'h00a, 16'h0000}};

	ctr_regs #(.OVERLOAD_CYC(20)) DUT (.clk_i, .rst_n_i, .reg_rd_i(rd), .reg_wr_i(wr),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
		.reset_flag_clr_i(clr), .supply_dv_i(sup), .motor_temp_i(temp), .motor_cur_i(cur),
		.motor_cur_lim_i(lim), .motor_run_i(run), .motor_speed_i(spd),
		.motor_speed_sel_i(sel), .jam_pin_i(pins[0]), .sensor_err_pin_i(pins[1]),
		.motor_short_pin_i(pins[2]), .motor_noconn_pin_i(pins[3]), .hall_err_pin_i(pins[4]),
		.motor_unused_pin_i(pins[5]), .us_accum_i(usa), .us_track1_i(ut1),
		.us_track2_i(ut2), .ds_accum_i(dsa), .ds_track1_i(dt1), .ds_track2_i(dt2),
		.us_release_i(ur), .ds_release_i(dr), .fwd_disch_i(fwd), .rev_disch_i(rev),
		.disch_track1_i(k1), .disch_track2_i(k2));

	ctr_plc_model plc (.clk_i, .reg_ack_i(ack), .reg_rdata_i(rdata), .reg_rd_o(rd),
		.reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata));

	// Clock at 20 MHz
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end

	// Word comparison
	task automatic chk(input ctr_word_t got, input ctr_word_t e);
		compares++;
		if (got !== e) begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, e);
		end
	endtask

	// Access with acknowledge check; writes only need the answer
	task automatic xfer(input logic w, input ctr_addr_t a, input ctr_word_t d, e);
		ctr_word_t q;
		logic      ok;
		plc.access(w, a, d, q, ok);
		if (w) q = e;
		if (ok !== 1'h1) q = ~e;
		chk(q, e);
	endtask

	task automatic rdw(input ctr_addr_t a, input ctr_word_t e);
		xfer(1'h0, a, 16'h0000, e);
	endtask

	// Wait n edges, then step just past the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic final_report;
		if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#(4000 * 50);
		failures++;
		final_report();
	end

	initial begin
		{rst_n_i, clr, fwd, rev, usa, dsa, pins} = '0;
		{ut1, ut2, dt1, dt2, ur, dr, k1, k2} = '0;
		run = 1'h1;
		{sup, temp, cur, spd} = {10'h0f0, 8'h19, 12'h032, 12'h064};
		{lim, sel} = {12'h064, 12'h064};
		step(6);
		rst_n_i = 1'h1;
		step(1);
		// Values straight after reset
		ex = '{0: 16'h0001, default: 16'h0000};
		foreach (offs[i]) rdw(offs[i], ex[i]);
		clr = 1'h1;
		step(1);
		clr = 1'h0;
		step(2);
		rdw(`CTR_OFF_STAT1, 16'h0000);
		// Status table
		foreach (rows[i]) begin
			{sup, temp, cur, pins, spd} = {rows[i].s, rows[i].t, rows[i].c, rows[i].p, rows[i].v};
			step(5);
			rdw(`CTR_OFF_STAT2, rows[i].e);
		end
		// Long stall turns into overload, clears when the motor stops
		spd = 12'h009;
		step(10);
		rdw(`CTR_OFF_STAT2, 16'h2008);
		step(20);
		rdw(`CTR_OFF_STAT2, 16'h3008);
		run = 1'h0;
		step(4);
		rdw(`CTR_OFF_STAT2, 16'h0000);
		// Current limit and selected speed are live inputs, not fixed
		run = 1'h1;
		{lim, sel} = {12'h031, 12'h05a};
		step(5);
		rdw(`CTR_OFF_STAT2, 16'h0208);
		{lim, sel} = {12'h032, 12'h05b};
		step(5);
		rdw(`CTR_OFF_STAT2, 16'h2008);
		{run, lim, sel} = {1'h0, 12'h064, 12'h064};
		// Accumulated cartons and release copies
		{usa, dsa, ut1, ut2, dt1, dt2, ur, dr} = {2'h3, 16'h1234, 16'h5678, 16'h9abc,
			16'hdef0, 16'h0003, 16'h0007};
		step(2);
		rdw(`CTR_OFF_US_TRK1, 16'h1234);
		rdw(`CTR_OFF_US_TRK2, 16'h5678);
		rdw(`CTR_OFF_DS_TRK1, 16'h9abc);
		rdw(`CTR_OFF_DS_TRK2, 16'hdef0);
		rdw(`CTR_OFF_US_REL, 16'h0003);
		rdw(`CTR_OFF_DS_REL, 16'h0007);
		{usa, dsa} = 2'h0;
		step(2);
		rdw(`CTR_OFF_US_TRK1, 16'h0000);
		rdw(`CTR_OFF_DS_TRK2, 16'h0000);
		// Back-to-back forward and reverse discharges
		{fwd, k1, k2} = {1'h1, 16'haaaa, 16'h5555};
		step(1);
		{fwd, rev, k1, k2} = {2'h1, 16'h0f0f, 16'hf0f0};
		step(1);
		{rev, k1, k2} = {1'h0, 16'hf0f0, 16'h0f0f};
		step(1);
		rdw(`CTR_OFF_FWD_TRK1, 16'haaaa);
		rdw(`CTR_OFF_FWD_TRK2, 16'h5555);
		rdw(`CTR_OFF_REV_TRK1, 16'h0f0f);
		rdw(`CTR_OFF_REV_TRK2, 16'hf0f0);
		// Writes to all twelve registers change nothing; an unmapped read at 00 gives zero
		ex = '{16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000, 16'h0f0f, 16'hf0f0,
			16'h0007, 16'h0000, 16'h0000, 16'haaaa, 16'h5555};
		foreach (offs[i]) xfer(1'h1, offs[i], 16'hffff, 16'h0000);
		foreach (offs[i]) rdw(offs[i], ex[i]);
		rdw(8'h00, 16'h0000);
		// Reset in mid-run raises the flag again
		rst_n_i = 1'h0;
		step(3);
		rst_n_i = 1'h1;
		step(1);
		rdw(`CTR_OFF_STAT1, 16'h0001);
		final_report();
	end
endmodule // tb_conveyor_status_tracking_regs
`default_nettype wire
